// [common/gq_pkg.sv]
// Shared constants and types of the input qualification block
package gq_pkg;
	// Pin and group organisation
	localparam int GQ_PINS = 64;
	localparam int GQ_GROUPS = 8;
	localparam int GQ_GROUP_PINS = 8;
	localparam int GQ_PRD_W = 8;
	localparam int GQ_CNT_W = 9;
	localparam int GQ_HIST_W = 6;

	// Register byte offsets on the bus
	localparam logic [7:0] GQ_OFF_A_PERIOD = 8'h00;
	localparam logic [7:0] GQ_OFF_A_QSEL_LO = 8'h04;
	localparam logic [7:0] GQ_OFF_A_QSEL_HI = 8'h08;
	localparam logic [7:0] GQ_OFF_B_PERIOD = 8'h0C;
	localparam logic [7:0] GQ_OFF_B_QSEL_LO = 8'h10;
	localparam logic [7:0] GQ_OFF_B_QSEL_HI = 8'h14;
	localparam logic [7:0] GQ_OFF_PROTECT = 8'h18;
	localparam logic [7:0] GQ_OFF_A_LEVEL = 8'h1C;
	localparam logic [7:0] GQ_OFF_B_LEVEL = 8'h20;

	// Field positions
	localparam int GQ_PROT_BIT = 0;

	// Reset values
	localparam logic [31:0] GQ_RST_PERIOD = 32'h00000000;
	localparam logic [31:0] GQ_RST_QSEL = 32'h00000000;
	localparam logic GQ_RST_PROT = 1'b0;

	// Period counter constants
	localparam logic [GQ_CNT_W-1:0] GQ_CNT_ZERO = 9'h000;
	localparam logic [GQ_CNT_W-1:0] GQ_CNT_ONE = 9'h001;

	// Agreement patterns of the sample history
	localparam logic [2:0] GQ_ALL3_HIGH = 3'h7;
	localparam logic [2:0] GQ_ALL3_LOW = 3'h0;
	localparam logic [5:0] GQ_ALL6_HIGH = 6'h3F;
	localparam logic [5:0] GQ_ALL6_LOW = 6'h00;

	typedef enum logic [1:0] {
		GQ_MODE_SYNC = 2'b00,
		GQ_MODE_Q3 = 2'b01,
		GQ_MODE_Q6 = 2'b10,
		GQ_MODE_ASYNC = 2'b11
	} gq_mode_t;
endpackage

// [rtl/gq_period_tick.sv]
// Sampling strobe generator for one group of eight pins
`timescale 1ns/1ns
module gq_period_tick
	import gq_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Period field of the group
	input wire logic [GQ_PRD_W-1:0] period_i,
	// One-cycle sampling strobe
	output logic tick_o
);
	logic [GQ_CNT_W-1:0] cnt_reg;
	logic [GQ_CNT_W-1:0] limit;

	// Zero gives one clock, else twice the field
	always_comb begin
		if (period_i == '0) begin
			limit = GQ_CNT_ZERO;
		end else begin
			limit = {period_i, 1'b0} - GQ_CNT_ONE;
		end
	end

	// Compare with >= so a shortened period cannot strand the counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= GQ_CNT_ZERO;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			if (cnt_reg >= limit) begin
				cnt_reg <= GQ_CNT_ZERO;
				tick_o <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + GQ_CNT_ONE;
				tick_o <= 1'b0;
			end
		end
	end
endmodule

// [rtl/gq_qualifier.sv]
// Multi-sample qualifier for one synchronised pin
`timescale 1ns/1ns
module gq_qualifier
	import gq_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Synchronised level, strobe, window length select
	input wire logic sample_i,
	input wire logic tick_i,
	input wire logic six_i,
	// Qualified level
	output logic level_o
);
	logic [GQ_HIST_W-1:0] hist_reg;
	logic [GQ_HIST_W-1:0] window;
	logic agree;

	assign window = {hist_reg[GQ_HIST_W-2:0], sample_i};

	// Window of three or six samples
	always_comb begin
		if (six_i) begin
			agree = (window == GQ_ALL6_HIGH) || (window == GQ_ALL6_LOW);
		end else begin
			agree = (window[2:0] == GQ_ALL3_HIGH) || (window[2:0] == GQ_ALL3_LOW);
		end
	end

	// Samples are taken only on the group strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hist_reg <= '0;
		end else if (ce_i && tick_i) begin
			hist_reg <= window;
		end
	end

	// Change only when the whole window agrees
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= 1'b0;
		end else if (ce_i && tick_i && agree) begin
			level_o <= sample_i;
		end
	end
endmodule

// [rtl/gq_top.sv]
// Input qualification for 64 pins with a Wishbone register slave
//
// Behaviour
// - Port B period register holds four 8-bit fields, one per group of eight pins 32-63.
// - A zero period gives one clock between samples, a value N gives 2N clocks.
// - Period and select registers change only while protected write permission is set.
// - Port A low select holds two bits per pin, pin n in bits 2n+1 and 2n.
// - Select 00 only synchronises the pin to the system clock.
// - Select 01 qualifies the pin over three samples.
// - Select 10 qualifies the pin over six samples.
// - Qualification samples are spaced by the period field of the pin's group.
// - Select 11 passes the pin straight to the peripheral path without synchronising.
// - Select 11 on the GPIO path acts as select 00.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module gq_top
	import gq_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Board pins
	input wire logic [GQ_PINS-1:0] pin_i,
	// Qualified inputs to GPIO data and peripherals
	output logic [GQ_PINS-1:0] gpio_data_o,
	output logic [GQ_PINS-1:0] periph_in_o
);
	logic [31:0] prd_a_reg;
	logic [31:0] prd_b_reg;
	logic [31:0] qsel_a_lo_reg;
	logic [31:0] qsel_a_hi_reg;
	logic [31:0] qsel_b_lo_reg;
	logic [31:0] qsel_b_hi_reg;
	logic prot_reg;
	logic req;
	logic wr;
	logic wr_ok;
	logic [31:0] rd_next;
	logic [63:0] prd_all;
	logic [127:0] qsel_all;
	logic [GQ_GROUPS-1:0] tick;
	logic [GQ_PINS-1:0] sync_lvl;
	logic [GQ_PINS-1:0] qual_lvl;
	logic [GQ_PINS-1:0] periph_reg;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// A request is taken once; ack then drops the next cycle
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	// Protected registers need the permission bit
	assign wr_ok = wr && prot_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= req;
		end
	end

	// The permission bit itself is never protected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prot_reg <= GQ_RST_PROT;
		end else if (ce_i && wr && wb_adr_i == GQ_OFF_PROTECT && wb_sel_i[0]) begin
			prot_reg <= wb_dat_i[GQ_PROT_BIT];
		end
	end

	// Period registers, byte-lane writes under permission
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prd_a_reg <= GQ_RST_PERIOD;
			prd_b_reg <= GQ_RST_PERIOD;
		end else if (ce_i && wr_ok) begin
			if (wb_adr_i == GQ_OFF_A_PERIOD) begin
				prd_a_reg <= merge(prd_a_reg, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == GQ_OFF_B_PERIOD) begin
				prd_b_reg <= merge(prd_b_reg, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Select registers, all fields reset to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qsel_a_lo_reg <= GQ_RST_QSEL;
			qsel_a_hi_reg <= GQ_RST_QSEL;
			qsel_b_lo_reg <= GQ_RST_QSEL;
			qsel_b_hi_reg <= GQ_RST_QSEL;
		end else if (ce_i && wr_ok) begin
			if (wb_adr_i == GQ_OFF_A_QSEL_LO) begin
				qsel_a_lo_reg <= merge(qsel_a_lo_reg, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == GQ_OFF_A_QSEL_HI) begin
				qsel_a_hi_reg <= merge(qsel_a_hi_reg, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == GQ_OFF_B_QSEL_LO) begin
				qsel_b_lo_reg <= merge(qsel_b_lo_reg, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == GQ_OFF_B_QSEL_HI) begin
				qsel_b_hi_reg <= merge(qsel_b_hi_reg, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Unmapped offsets read as zero
	always_comb begin
		rd_next = 32'h00000000;
		unique case (wb_adr_i)
			GQ_OFF_A_PERIOD: rd_next = prd_a_reg;
			GQ_OFF_A_QSEL_LO: rd_next = qsel_a_lo_reg;
			GQ_OFF_A_QSEL_HI: rd_next = qsel_a_hi_reg;
			GQ_OFF_B_PERIOD: rd_next = prd_b_reg;
			GQ_OFF_B_QSEL_LO: rd_next = qsel_b_lo_reg;
			GQ_OFF_B_QSEL_HI: rd_next = qsel_b_hi_reg;
			GQ_OFF_PROTECT: rd_next[GQ_PROT_BIT] = prot_reg;
			GQ_OFF_A_LEVEL: rd_next = gpio_data_o[31:0];
			GQ_OFF_B_LEVEL: rd_next = gpio_data_o[63:32];
			default: rd_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (ce_i && req) begin
			wb_dat_o <= rd_next;
		end
	end

	// Pin n takes select bits 2n+1:2n across the four registers
	assign qsel_all = {qsel_b_hi_reg, qsel_b_lo_reg, qsel_a_hi_reg, qsel_a_lo_reg};
	assign prd_all = {prd_b_reg, prd_a_reg};

	genvar g;
	generate
		for (g = 0; g < GQ_GROUPS; g++) begin : g_group
			// One strobe per group of eight pins
			gq_period_tick u_tick (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.period_i(prd_all[GQ_PRD_W*g +: GQ_PRD_W]),
				.tick_o(tick[g])
			);
		end
	endgenerate

	genvar n;
	generate
		for (n = 0; n < GQ_PINS; n++) begin : g_pin
			logic meta_reg;
			logic sync_reg;
			gq_mode_t mode;

			assign mode = gq_mode_t'(qsel_all[2*n +: 2]);

			// Two flops bring the pin into the clock domain
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else if (ce_i) begin
					meta_reg <= pin_i[n];
					sync_reg <= meta_reg;
				end
			end
			assign sync_lvl[n] = sync_reg;

			gq_qualifier u_qual (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.sample_i(sync_reg),
				.tick_i(tick[n / GQ_GROUP_PINS]),
				.six_i(mode == GQ_MODE_Q6),
				.level_o(qual_lvl[n])
			);

			// GPIO path treats select 11 as plain synchronisation
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					gpio_data_o[n] <= 1'b0;
					periph_reg[n] <= 1'b0;
				end else if (ce_i) begin
					unique case (mode)
						GQ_MODE_Q3, GQ_MODE_Q6: begin
							gpio_data_o[n] <= qual_lvl[n];
							periph_reg[n] <= qual_lvl[n];
						end
						GQ_MODE_SYNC, GQ_MODE_ASYNC: begin
							gpio_data_o[n] <= sync_lvl[n];
							periph_reg[n] <= sync_lvl[n];
						end
					endcase
				end
			end

			// Under select 11 the peripheral path bypasses every flop; the pin may glitch through
			always_comb begin
				if (mode == GQ_MODE_ASYNC) begin
					periph_in_o[n] = pin_i[n];
				end else begin
					periph_in_o[n] = periph_reg[n];
				end
			end
		end
	endgenerate
endmodule

// [tb/gq_pins_model.sv]
// Board-side model that presents the bench's pin levels
`timescale 1ns/1ns
module gq_pins_model (
	// Clock and requested levels
	input wire logic clk_i,
	input wire logic [63:0] level_i,
	// Board pins
	output logic [63:0] pin_o = 64'h0
);
	// Levels move just after an edge, as an asynchronous pin would
	always @(posedge clk_i) begin
		pin_o <= level_i;
	end
endmodule

// [tb/gq_top_asserts.sv]
// Bus, reset and pin-path assertions for the qualification block
`timescale 1ns/1ns
module gq_top_asserts
	import gq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [GQ_PINS-1:0] pin_i,
	input wire logic [GQ_PINS-1:0] gpio_data_o,
	input wire logic [GQ_PINS-1:0] periph_in_o
);
	logic tk, wr, prot_reg;
	logic [31:0] qlo_reg;
	logic [2:0] age_reg;
	assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
	assign wr = tk & wb_we_i;
	// Shadow of the permission bit and the low select word
	always_ff @(posedge clk_i) begin
		if (rst_i) prot_reg <= 1'b0;
		else if (wr && wb_adr_i == GQ_OFF_PROTECT && wb_sel_i[0]) prot_reg <= wb_dat_i[0];
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) qlo_reg <= 32'h0;
		else for (int b = 0; b < 4; b++) begin
			if (wr && wb_adr_i == GQ_OFF_A_QSEL_LO && prot_reg && wb_sel_i[b]) begin
				qlo_reg[8*b+:8] <= wb_dat_i[8*b+:8];
			end
		end
	end
	// Pipeline is only trusted once it has refilled after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) age_reg <= 3'h0;
		else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_lat; tk |=> wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack late");
	property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_rst_out;
		disable iff (1'b0) rst_i |=> !wb_ack_o && gpio_data_o == 64'h0 && periph_in_o == 64'h0;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
	property p_read_qlo;
		tk && !wb_we_i && wb_adr_i == GQ_OFF_A_QSEL_LO |=> wb_dat_o == qlo_reg;
	endproperty
	a_read_qlo: assert property (p_read_qlo) else $error("select read wrong");
	property p_read_prot;
		tk && !wb_we_i && wb_adr_i == GQ_OFF_PROTECT |=> wb_dat_o[0] == prot_reg;
	endproperty
	a_read_prot: assert property (p_read_prot) else $error("permission read wrong");
	property p_sync;
		(age_reg == 3'h7 && qlo_reg[1:0] == 2'b00) [*4] |->
			gpio_data_o[0] == $past(pin_i[0], 3) && periph_in_o[0] == $past(pin_i[0], 3);
	endproperty
	a_sync: assert property (p_sync) else $error("sync path wrong");
	property p_async; qlo_reg[1:0] == 2'b11 |-> periph_in_o[0] == pin_i[0]; endproperty
	a_async: assert property (p_async) else $error("async path wrong");
	property p_gpio11;
		(age_reg == 3'h7 && qlo_reg[1:0] == 2'b11) [*4] |-> gpio_data_o[0] == $past(pin_i[0], 3);
	endproperty
	a_gpio11: assert property (p_gpio11) else $error("gpio path wrong");
	c_write: cover property (wr && wb_adr_i == GQ_OFF_A_QSEL_LO && prot_reg);
	c_async: cover property (qlo_reg[1:0] == 2'b11 && $rose(pin_i[0]));
	c_qual: cover property ($rose(gpio_data_o[15]));
endmodule
bind gq_top gq_top_asserts gq_top_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pin_i(pin_i), .gpio_data_o(gpio_data_o), .periph_in_o(periph_in_o));

// [tb/gq_top_test.sv]
// Register and pin-path tests of the qualification block
`timescale 1ns/1ns
module gq_top_test;
	import gq_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0, wb_rdat, rq;
	logic [63:0] lvl = 64'h0, pins, gpio, periph;
	logic ce = 1'b1;
	int bad_count = 0, total_checks = 0, cycles = 0;
	gq_top gq_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pin_i(pins),
		.gpio_data_o(gpio), .periph_in_o(periph));
	gq_pins_model gq_pins_model_inst (.clk_i(clk_i), .level_i(lvl), .pin_o(pins));
	initial forever #20 clk_i = ~clk_i;
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Entered just after an edge; leaves one idle cycle after the ack
	task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_wdat <= d;
		// Only the bench watchdog ends a wait for the ack
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		rq = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 4'h0, 32'h0);
		check($sformatf("reg %h", a), rq, e);
	endtask
	// Counts edges from the pin change until the qualified level follows
	task automatic step(input int p, input int lo, input int hi);
		int n;
		lvl[p] <= 1'b1;
		@(posedge clk_i);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			#1;
		end while (gpio[p] !== 1'b1 && n < hi + 5);
		check($sformatf("delay pin %0d", p), 32'(n >= lo && n <= hi), 32'h1);
		@(posedge clk_i);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
		xfer(1'b1, GQ_OFF_A_QSEL_LO, 4'hF, 32'h40000003);
		rd(GQ_OFF_A_QSEL_LO, 32'h0);
		xfer(1'b1, GQ_OFF_PROTECT, 4'h1, 32'h1);
		rd(GQ_OFF_PROTECT, 32'h1);
		xfer(1'b1, GQ_OFF_A_QSEL_LO, 4'hF, 32'h40000003);
		rd(GQ_OFF_A_QSEL_LO, 32'h40000003);
		xfer(1'b1, GQ_OFF_A_QSEL_HI, 4'hF, 32'h80000000);
		rd(GQ_OFF_A_QSEL_HI, 32'h80000000);
		xfer(1'b1, GQ_OFF_B_PERIOD, 4'hF, 32'h02000001);
		xfer(1'b1, GQ_OFF_B_PERIOD, 4'h2, 32'h1234FF56);
		rd(GQ_OFF_B_PERIOD, 32'h0200FF01);
		rd(8'h24, 32'h0);
		xfer(1'b1, GQ_OFF_B_QSEL_LO, 4'hF, 32'h00010002);
		xfer(1'b1, GQ_OFF_B_QSEL_HI, 4'hF, 32'h00010000);
		lvl[0] <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check("periph pin 0", periph[0], 1'b1);
		check("gpio pin 0", gpio[0], 1'b0);
		@(posedge clk_i);
		lvl[15] <= 1'b1;
		@(posedge clk_i);
		lvl[15] <= 1'b0;
		repeat (12) @(posedge clk_i);
		#1;
		check("glitch pin 15", gpio[15], 1'b0);
		check("gpio pin 0 synced", gpio[0], 1'b1);
		@(posedge clk_i);
		step(1, 3, 3);
		step(15, 5, 8);
		step(32, 13, 17);
		step(40, 1023, 1535);
		step(56, 11, 17);
		// Clock enable low must freeze the synchroniser
		ce <= 1'b0;
		lvl[1] <= 1'b0;
		repeat (6) @(posedge clk_i);
		#1;
		check("frozen pin 1", gpio[1], 1'b1);
		@(posedge clk_i);
		ce <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		check("released pin 1", gpio[1], 1'b0);
		@(posedge clk_i);
		rd(GQ_OFF_A_LEVEL, 32'h00008001);
		rd(GQ_OFF_B_LEVEL, 32'h01000101);
		xfer(1'b1, GQ_OFF_PROTECT, 4'h1, 32'h0);
		xfer(1'b1, GQ_OFF_B_PERIOD, 4'hF, 32'h0);
		rd(GQ_OFF_B_PERIOD, 32'h0200FF01);
		summarize();
	end
endmodule
